//--- rtl/smc_standby_ctrl.sv
// standby control register, low-power mode select and settle counter
// assumes the cpu raises sleep_cmd for one cycle and wake_req on a cancelling interrupt
`timescale 1ns/1ps
module smc_standby_ctrl import smc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic register_window_select,
	input wire logic sleep_cmd,
	input wire logic wake_req,
	input wire logic to_sub_sel,
	input wire logic wake_to_sub,
	input wire logic subclock_input_enable,
	output logic [2:0] mode,
	output logic cpu_clk_ready,
	output logic bus_clk_en,
	output logic use_subclock
);
	smc_mode_type mode_r;
	smc_mode_type mode_nxt;
	logic [7:0] standby_control_r;
	logic [18:0] settle_cnt_r;
	logic [18:0] settle_target;
	logic deep_sleep_select;
	logic [2:0] wait_sel;
	logic [2:0] div_sel;
	logic win_open;

	assign deep_sleep_select = standby_control_r[SMC_SEL_BIT];
	assign wait_sel = standby_control_r[SMC_WAIT_LSB +: 3];
	assign div_sel = standby_control_r[SMC_DIV_LSB +: 3];
	assign win_open = !register_window_select;

	// only reset and software writes touch the register; mode changes never do
	always_ff @(posedge core_clk) begin
		if (rst) begin
			standby_control_r <= SMC_STANDBY_CONTROL_RST;
		end else if (reg_wr && win_open && reg_addr == SMC_STANDBY_CONTROL_OFS) begin
			standby_control_r <= reg_wdata & SMC_WRITE_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd && win_open && reg_addr == SMC_STANDBY_CONTROL_OFS) begin
			reg_rdata <= standby_control_r;
		end else if (reg_rd && reg_addr == SMC_STATUS_OFS) begin
			reg_rdata <= {4'h0, cpu_clk_ready, mode_r};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	always_comb begin
		case (wait_sel)
			3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: settle_target = SMC_WAIT_BASE_STATES << wait_sel;
			SMC_WAIT_SHORT: settle_target = SMC_WAIT_SHORT_STATES;
			default: settle_target = SMC_WAIT_BASE_STATES << SMC_DIV_MAX; // reserved code: longest wait
		endcase
	end

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			SMC_HIGH, SMC_MEDIUM: begin
				if (sleep_cmd) begin
					if (!deep_sleep_select) begin
						mode_nxt = SMC_SLEEP;
					end else if (to_sub_sel) begin
						mode_nxt = SMC_WATCH;
					end else begin
						mode_nxt = SMC_STANDBY;
					end
				end else begin
					mode_nxt = (div_sel == 3'h0) ? SMC_HIGH : SMC_MEDIUM;
				end
			end
			SMC_SUBACTIVE: begin
				if (sleep_cmd) begin
					if (!deep_sleep_select) begin
						mode_nxt = SMC_SUBSLEEP;
					end else if (to_sub_sel) begin
						mode_nxt = SMC_WATCH;
					end else begin
						mode_nxt = SMC_SETTLE;
					end
				end
			end
			SMC_SLEEP: if (wake_req) mode_nxt = (div_sel == 3'h0) ? SMC_HIGH : SMC_MEDIUM;
			SMC_SUBSLEEP: if (wake_req) mode_nxt = SMC_SUBACTIVE;
			SMC_STANDBY: if (wake_req) mode_nxt = SMC_SETTLE;
			SMC_WATCH: if (wake_req) mode_nxt = wake_to_sub ? SMC_SUBACTIVE : SMC_SETTLE;
			SMC_SETTLE: begin
				if (settle_cnt_r + 19'h1 >= settle_target) begin
					mode_nxt = SMC_HIGH;
				end
			end
			default: mode_nxt = SMC_HIGH;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_r <= SMC_HIGH;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// counter restarts whenever the oscillator restarts
	always_ff @(posedge core_clk) begin
		if (rst || mode_r != SMC_SETTLE) begin
			settle_cnt_r <= 19'h0;
		end else begin
			settle_cnt_r <= settle_cnt_r + 19'h1;
		end
	end

	assign mode = mode_r;
	assign cpu_clk_ready = (mode_r != SMC_SETTLE && mode_r != SMC_STANDBY && mode_r != SMC_WATCH);
	// slow modes run from the subclock only when its input is enabled
	assign use_subclock = subclock_input_enable && (mode_r == SMC_SUBACTIVE || mode_r == SMC_SUBSLEEP
		|| mode_r == SMC_WATCH);

	smc_clk_div u_div (
		.core_clk(core_clk),
		.rst(rst),
		.div_sel(div_sel),
		.bus_clk_en(bus_clk_en)
	);

	sequence s_window_write;
		reg_wr && register_window_select && reg_addr == SMC_STANDBY_CONTROL_OFS;
	endsequence
	sequence s_standby_cancel;
		mode_r == SMC_STANDBY && wake_req;
	endsequence
	sequence s_watch_cancel;
		mode_r == SMC_WATCH && wake_req && !wake_to_sub;
	endsequence
	sequence s_settle_begin;
		mode_r == SMC_SETTLE && settle_cnt_r == 19'h0 && !cpu_clk_ready;
	endsequence

	// register port
	a_window_blocks: assert property (@(posedge core_clk) disable iff (rst)
		s_window_write |=> $stable(standby_control_r))
		else $error("write passed a closed register window");
	a_window_reads: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd && register_window_select && reg_addr == SMC_STANDBY_CONTROL_OFS) |=> reg_rdata == 8'h00)
		else $error("read passed a closed register window");
	a_open_write: assert property (@(posedge core_clk) disable iff (rst)
		(reg_wr && !register_window_select && reg_addr == SMC_STANDBY_CONTROL_OFS)
		|=> standby_control_r == ($past(reg_wdata) & SMC_WRITE_MASK))
		else $error("open window write not stored");
	a_status_read: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == SMC_STATUS_OFS) |=> reg_rdata[2:0] == $past(mode_r))
		else $error("status read lost the mode");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
		standby_control_r[3] == 1'b0)
		else $error("reserved bit set");

	// mode selection
	a_sleep_shallow: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_cmd && !deep_sleep_select && (mode_r == SMC_HIGH || mode_r == SMC_MEDIUM))
		|=> mode_r == SMC_SLEEP)
		else $error("sleep did not enter sleep mode");
	a_sleep_deep: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_cmd && deep_sleep_select && (mode_r == SMC_HIGH || mode_r == SMC_MEDIUM))
		|=> (mode_r == SMC_STANDBY || mode_r == SMC_WATCH))
		else $error("sleep with select set took wrong mode");
	a_standby_hold: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_STANDBY && !wake_req) |=> mode_r == SMC_STANDBY)
		else $error("standby left without a cancel");
	a_sub_sleep: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_cmd && !deep_sleep_select && mode_r == SMC_SUBACTIVE) |=> mode_r == SMC_SUBSLEEP)
		else $error("subactive sleep did not enter subsleep");
	a_sub_deep: assert property (@(posedge core_clk) disable iff (rst)
		(sleep_cmd && deep_sleep_select && mode_r == SMC_SUBACTIVE)
		|=> (mode_r == SMC_WATCH || mode_r == SMC_SETTLE))
		else $error("subactive sleep with select set took wrong mode");
	a_subsleep_wake: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_SUBSLEEP && wake_req) |=> mode_r == SMC_SUBACTIVE)
		else $error("subsleep cancel did not return to subactive");
	a_select_kept: assert property (@(posedge core_clk) disable iff (rst)
		(!reg_wr && wake_req) |=> $stable(deep_sleep_select))
		else $error("standby select changed without a write");
	a_speed_follow: assert property (@(posedge core_clk) disable iff (rst)
		((mode_r == SMC_HIGH || mode_r == SMC_MEDIUM) && !sleep_cmd && div_sel != 3'h0)
		|=> mode_r == SMC_MEDIUM)
		else $error("divided bus clock not in medium speed");
	a_full_speed: assert property (@(posedge core_clk) disable iff (rst)
		(div_sel == 3'h0) |-> bus_clk_en)
		else $error("full speed enable not continuous");

	// settle counter and clocks
	a_standby_cancel: assert property (@(posedge core_clk) disable iff (rst)
		s_standby_cancel |=> s_settle_begin)
		else $error("standby cancel did not start the settle count");
	a_watch_cancel: assert property (@(posedge core_clk) disable iff (rst)
		s_watch_cancel |=> s_settle_begin)
		else $error("watch cancel did not start the settle count");
	a_short_wait: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_SETTLE && settle_cnt_r == 19'h0 && wait_sel == SMC_WAIT_SHORT && !reg_wr)
		|-> ##15 mode_r == SMC_SETTLE ##1 mode_r == SMC_HIGH)
		else $error("sixteen state wait wrong length");
	a_base_wait: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_SETTLE && wait_sel == 3'h0 && settle_cnt_r == SMC_WAIT_BASE_STATES - 19'h1)
		|=> mode_r == SMC_HIGH)
		else $error("shortest recommended wait wrong length");
	a_settle_floor: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_SETTLE && settle_cnt_r < SMC_WAIT_SHORT_STATES - 19'h1) |=> mode_r == SMC_SETTLE)
		else $error("settle ended before the shortest wait");
	a_settle_release: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_SETTLE) |-> !cpu_clk_ready)
		else $error("clock released during settle");
	a_fast_clock: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_HIGH || mode_r == SMC_MEDIUM) |-> cpu_clk_ready)
		else $error("cpu clock held in a running mode");
	a_subclock_use: assert property (@(posedge core_clk) disable iff (rst)
		(mode_r == SMC_WATCH && subclock_input_enable) |-> use_subclock)
		else $error("watch mode not on subclock");
	a_subclock_off: assert property (@(posedge core_clk) disable iff (rst)
		!subclock_input_enable |-> !use_subclock)
		else $error("subclock used while its input is disabled");
endmodule // smc_standby_ctrl

//--- rtl/smc_pkg.sv
// standby mode control: register layout, mode codes and wait counts
// assumes one 20 MHz system clock and a plain register port from the cpu
// Overview of operation
// - control register access only while register window bit clear; status reads always
// - sleep in fast modes: bit7 picks sleep/standby, watch instead if to_sub_sel
// - sleep in subactive: bit7 picks subsleep/watch, settle instead if to_sub_sel clear
// - interrupts never alter the standby select bit
// - bits 6..4 pick oscillation settle wait
// - codes 0..5 give 8192..262144 states
// - bits 2..0 pick bus master clock divider
// - subclock drives cpu in slow modes if enabled
package smc_pkg;
	localparam logic [7:0] SMC_STANDBY_CONTROL_OFS = 8'h00;
	localparam logic [7:0] SMC_STATUS_OFS = 8'h01;
	localparam logic [7:0] SMC_STANDBY_CONTROL_RST = 8'h00;
	localparam logic [7:0] SMC_WRITE_MASK = 8'hF7;
	localparam int SMC_SEL_BIT = 7;
	localparam int SMC_WAIT_LSB = 4;
	localparam int SMC_DIV_LSB = 0;
	localparam logic [2:0] SMC_WAIT_RESERVED = 3'h6;
	localparam logic [2:0] SMC_WAIT_SHORT = 3'h7;
	localparam logic [18:0] SMC_WAIT_SHORT_STATES = 19'h00010;
	localparam logic [18:0] SMC_WAIT_BASE_STATES = 19'h02000;
	localparam logic [2:0] SMC_DIV_MAX = 3'h5;
	localparam int SMC_DIV_W = 5;
	typedef enum logic [2:0] {
		SMC_HIGH = 3'b000,
		SMC_MEDIUM = 3'b001,
		SMC_SLEEP = 3'b010,
		SMC_STANDBY = 3'b011,
		SMC_SUBACTIVE = 3'b100,
		SMC_SUBSLEEP = 3'b101,
		SMC_WATCH = 3'b110,
		SMC_SETTLE = 3'b111
	} smc_mode_type;
endpackage

//--- rtl/smc_clk_div.sv
// bus master clock enable divider
// assumes a single clock; output is a one-cycle enable pulse, held high when div_sel is 0
`timescale 1ns/1ps
module smc_clk_div import smc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [2:0] div_sel,
	output logic bus_clk_en
);
	logic [SMC_DIV_W-1:0] cnt_r;
	logic [SMC_DIV_W-1:0] mask;
	always_comb begin
		case (div_sel)
			3'h0: mask = 5'h00;
			3'h1: mask = 5'h01;
			3'h2: mask = 5'h03;
			3'h3: mask = 5'h07;
			3'h4: mask = 5'h0F;
			3'h5: mask = 5'h1F;
			default: mask = 5'h00; // prohibited codes fall back to full speed
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_r <= 5'h00;
		end else begin
			cnt_r <= (cnt_r + 5'h01) & mask;
		end
	end
	assign bus_clk_en = ((cnt_r & mask) == mask);
	a_div_period: assert property (@(posedge core_clk) disable iff (rst)
		(div_sel == 3'h1 && $past(div_sel) == 3'h1 && bus_clk_en) |=> !bus_clk_en)
		else $error("divide by two enable not alternating");
endmodule // smc_clk_div

//--- verif/smc_standby_ctrl_test.sv
// self-checking bench for the standby control register, mode select and settle counter
// assumes the design alone on one 20 MHz clock; the bench drives every port itself
`timescale 1ns/1ps
module smc_standby_ctrl_test import smc_pkg::*;;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, register_window_select = 0;
	logic sleep_cmd = 0, wake_req = 0, to_sub_sel = 0, wake_to_sub = 0, subclock_input_enable = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
	logic [2:0] mode;
	logic cpu_clk_ready, bus_clk_en, use_subclock;
	int errors = 0, samples_checked = 0, n;
	logic [2:0] codes [3] = '{3'h7, 3'h0, 3'h1};
	smc_standby_ctrl i_smc_standby_ctrl (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.register_window_select(register_window_select), .sleep_cmd(sleep_cmd), .wake_req(wake_req),
		.to_sub_sel(to_sub_sel), .wake_to_sub(wake_to_sub), .subclock_input_enable(subclock_input_enable),
		.mode(mode), .cpu_clk_ready(cpu_clk_ready), .bus_clk_en(bus_clk_en), .use_subclock(use_subclock));
	always #25 core_clk = ~core_clk;
	function automatic int settle_states(logic [2:0] c);
		return (c == 3'h7) ? 16 : (8192 << c);
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp, string msg);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v, logic win);
		@(posedge core_clk);
		register_window_select <= win;
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic win, logic [7:0] exp);
		@(posedge core_clk);
		register_window_select <= win;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, "register read");
	endtask
	task automatic pulse(logic slp);
		@(posedge core_clk);
		if (slp) sleep_cmd <= 1'b1;
		else wake_req <= 1'b1;
		@(posedge core_clk);
		sleep_cmd <= 1'b0;
		wake_req <= 1'b0;
		#1;
	endtask
	// slow-mode clock routing and cpu clock gating are watched on every cycle
	always @(negedge core_clk) if (!rst) begin
		chk({7'h00, use_subclock}, {7'h00, subclock_input_enable && (mode inside {3'h4, 3'h5, 3'h6})}, "subclock");
		chk({7'h00, cpu_clk_ready}, {7'h00, !(mode inside {3'h3, 3'h6, 3'h7})}, "cpu clock");
	end
	always @(posedge core_clk) subclock_input_enable <= 1'($urandom);
	initial begin
		void'($urandom(14));
		do_reset();
		rd(SMC_STANDBY_CONTROL_OFS, 1'b0, SMC_STANDBY_CONTROL_RST);
		for (int i = 0; i < 24; i++) begin
			d = 8'($urandom);
			n = $urandom % 2;
			wr(SMC_STANDBY_CONTROL_OFS, d, 1'(n));
			if (n == 0) rd(SMC_STANDBY_CONTROL_OFS, 1'b0, d & SMC_WRITE_MASK);
			rd(SMC_STANDBY_CONTROL_OFS, 1'b1, 8'h00);
		end
		for (int c = 0; c < 6; c++) begin
			wr(SMC_STANDBY_CONTROL_OFS, 8'(c), 1'b0);
			n = 0;
			repeat (64) @(negedge core_clk) n += int'(bus_clk_en);
			chk(8'(n), 8'(64 >> c), "bus clock pulses");
			chk(mode, (c == 0) ? SMC_HIGH : SMC_MEDIUM, "speed mode");
		end
		wr(SMC_STANDBY_CONTROL_OFS, 8'h00, 1'b0);
		pulse(1'b1);
		chk({5'h00, mode}, {5'h00, SMC_SLEEP}, "sleep entry");
		pulse(1'b0);
		chk(mode, SMC_HIGH, "sleep cancel");
		foreach (codes[k]) begin
			do_reset();
			rd(SMC_STANDBY_CONTROL_OFS, 1'b0, SMC_STANDBY_CONTROL_RST);
			d = {1'b1, codes[k], 4'h0};
			wr(SMC_STANDBY_CONTROL_OFS, d, 1'b0);
			pulse(1'b1);
			chk({5'h00, mode}, {5'h00, SMC_STANDBY}, "standby entry");
			pulse(1'b0);
			n = 0;
			while (mode === SMC_SETTLE && n < 20000) begin
				@(posedge core_clk);
				#1 n++;
			end
			chk(n, settle_states(d[6:4]), "settle length");
			chk({5'h00, mode}, {5'h00, SMC_HIGH}, "after settle");
			rd(SMC_STANDBY_CONTROL_OFS, 1'b0, d);
		end
		do_reset();
		to_sub_sel <= 1'b1;
		wake_to_sub <= 1'b1;
		wr(SMC_STANDBY_CONTROL_OFS, 8'h80, 1'b0);
		pulse(1'b1);
		chk({7'h00, mode inside {SMC_WATCH, SMC_SUBACTIVE}}, 8'h01, "slow entry");
		if (mode === SMC_WATCH) pulse(1'b0);
		chk({5'h00, mode}, {5'h00, SMC_SUBACTIVE}, "watch cancel");
		wr(SMC_STANDBY_CONTROL_OFS, 8'h00, 1'b0);
		pulse(1'b1);
		chk({5'h00, mode}, {5'h00, SMC_SUBSLEEP}, "subsleep entry");
		pulse(1'b0);
		chk(mode, SMC_SUBACTIVE, "subsleep cancel");
		wr(SMC_STANDBY_CONTROL_OFS, 8'hF0, 1'b0);
		pulse(1'b1);
		chk(mode, SMC_WATCH, "subactive to watch");
		wake_to_sub <= 1'b0;
		pulse(1'b0);
		repeat (20) @(negedge core_clk);
		chk(mode, SMC_HIGH, "watch cancel to high");
		rd(SMC_STATUS_OFS, 1'b1, {4'h0, 1'b1, SMC_HIGH});
		repeat (4) @(posedge core_clk);
		print_verdict();
	end
endmodule // smc_standby_ctrl_test
